// File: core/scm_pkg.sv
package scm_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] SCM_ADDR_SYS_CTRL = 8'h00; // system control
    localparam logic [7:0] SCM_ADDR_STATUS = 8'h04; // read-only state
    // ==========================================================
    // system control field positions
    localparam int SCM_BIT_TIMER_SRC = 6; // timer clock source select
    localparam int SCM_BIT_CPU_SRC = 5; // cpu clock source select
    localparam int SCM_BIT_IDLE = 4; // idle enable on sleep
    localparam int SCM_BIT_RC_HI = 1; // rc frequency select high
    localparam int SCM_BIT_RC_LO = 0; // rc frequency select low
    localparam logic [7:0] SCM_SYS_CTRL_MASK = 8'h73; // implemented bits
    // ==========================================================
    // reset values
    localparam logic SCM_RST_TIMER_SRC = 1'b1; // main clock to timer
    localparam logic SCM_RST_CPU_SRC = 1'b1; // main oscillator to cpu
    localparam logic SCM_RST_IDLE = 1'b0; // sleep on sleep_instruction
    // ==========================================================
    // rc frequency codes
    localparam logic [1:0] SCM_RC_4M = 2'h3;
    localparam logic [1:0] SCM_RC_16M = 2'h2;
    localparam logic [1:0] SCM_RC_8M = 2'h1;
    localparam logic [1:0] SCM_RC_1M = 2'h0;
    // ==========================================================
    // timing
    localparam int SCM_CLK_MHZ = 250; // reference clock rate
    localparam int SCM_HOLD_4M_NS = 5000; // 4 mhz settle time
    localparam int SCM_HOLD_16M_NS = 1500; // 16 mhz settle time
    localparam int SCM_HOLD_8M_NS = 3000; // 8 mhz settle time
    localparam int SCM_HOLD_1M_NS = 24000; // 1 mhz settle time
    // least times round up to whole cycles
    localparam int SCM_HOLD_4M_CYC =
        (SCM_HOLD_4M_NS * SCM_CLK_MHZ + 999) / 1000;
    localparam int SCM_HOLD_16M_CYC =
        (SCM_HOLD_16M_NS * SCM_CLK_MHZ + 999) / 1000;
    localparam int SCM_HOLD_8M_CYC =
        (SCM_HOLD_8M_NS * SCM_CLK_MHZ + 999) / 1000;
    localparam int SCM_HOLD_1M_CYC =
        (SCM_HOLD_1M_NS * SCM_CLK_MHZ + 999) / 1000;
    localparam int SCM_WAKE_XTAL_CNT = 510; // cpu clocks, crystal normal
    localparam int SCM_WAKE_SHORT_CNT = 8; // cpu clocks, green or rc
    localparam int SCM_CNT_W = 13; // hold counter width
    // ==========================================================
    // operating states
    typedef enum logic [2:0] {
        SCM_RUN, SCM_SLEEP, SCM_IDLE, SCM_OSC_WAIT, SCM_WAKE_COUNT,
        SCM_FREQ_HOLD
    } scm_state_t;
endpackage : scm_pkg

// File: core/scm_sync.sv
`timescale 1ns/1ps
// ==========================================================
// three-stage input synchroniser with agreement filter
module scm_sync (
    input wire logic clock,
    input wire logic rstn,
    input wire logic pin,
    output logic level,
    output logic rise
);
    import scm_pkg::*;

    // all state of the synchroniser
    typedef struct packed {
        logic ff1; // metastability stage, read only by ff2
        logic ff2;
        logic ff3;
        logic level; // filtered level
        logic rise; // one-cycle pulse on accepted rising change
    } scm_sync_st_t;

    scm_sync_st_t st;
    scm_sync_st_t next_st;

    // next state: a change counts once ff2 and ff3 agree
    always_comb begin
        next_st = st;
        next_st.ff1 = pin;
        next_st.ff2 = st.ff1;
        next_st.ff3 = st.ff2;
        next_st.rise = 1'b0;
        if (st.ff2 == st.ff3 && st.ff3 != st.level) begin
            next_st.level = st.ff3;
            next_st.rise = st.ff3;
        end
    end

    // state register
    always_ff @(posedge clock) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;
    assign rise = st.rise;
endmodule : scm_sync

// File: core/scm_top.sv
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
module scm_top #(
    parameter int HOLD_1M_CYC = scm_pkg::SCM_HOLD_1M_CYC // 24 us hold
) (
    input wire logic clock,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // configuration word straps
    input wire logic [1:0] cfg_rc_freq_sel, // word one bits six and five
    input wire logic cfg_crystal, // main source is a crystal
    input wire logic cfg_clk_div4, // timer clock is main over four, else main over two
    // oscillator side pins
    input wire logic main_osc_clock, // main oscillator clock pin
    input wire logic sub_osc_clock, // 16 khz sub oscillator pin
    input wire logic osc_stable, // selected oscillator has settled
    input wire logic wake_req, // wake-up event pin
    // cpu side, same clock
    input wire logic sleep_instruction, // one-cycle pulse
    output logic cpu_clk_en,
    output logic timer_clk_en,
    output logic main_osc_en,
    output logic [1:0] rc_freq_sel, // rc_freq_sel_hi, rc_freq_sel_lo
    output logic cpu_hold,
    output logic sleep_mode,
    output logic idle_mode
);
    import scm_pkg::*;

    // ==========================================================
    // synchronised pins
    logic main_tick; // accepted rising edge of main clock
    logic sub_tick; // accepted rising edge of sub clock
    logic stable_lvl; // filtered oscillator stable level
    logic wake_tick; // accepted wake event

    scm_sync u_sync_main (
        .clock(clock), .rstn(rstn), .pin(main_osc_clock),
        .level(), .rise(main_tick)
    );
    scm_sync u_sync_sub (
        .clock(clock), .rstn(rstn), .pin(sub_osc_clock),
        .level(), .rise(sub_tick)
    );
    scm_sync u_sync_stable (
        .clock(clock), .rstn(rstn), .pin(osc_stable),
        .level(stable_lvl), .rise()
    );
    scm_sync u_sync_wake (
        .clock(clock), .rstn(rstn), .pin(wake_req),
        .level(), .rise(wake_tick)
    );

    // ==========================================================
    // state of the block
    typedef struct packed {
        scm_state_t state; // operating state
        logic timer_src; // timer_clock_source_sel
        logic cpu_src; // cpu_clock_source_sel
        logic idle_en; // idle enable
        logic [1:0] rc_sel; // rc frequency select
        logic [SCM_CNT_W-1:0] cnt; // hold and wake counter
        logic [1:0] div; // main tick divider for the timer
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic cpu_clk_en;
        logic timer_clk_en;
        logic main_osc_en;
        logic cpu_hold; // registered state decodes for the outputs
        logic sleep_mode;
        logic idle_mode;
    } scm_st_t;

    scm_st_t st;
    scm_st_t next_st;

    // ==========================================================
    // helpers
    logic apb_access; // access phase, answer cycle
    logic apb_done; // transfer completes this edge
    logic cpu_tick; // tick of selected cpu source
    logic [7:0] sys_ctrl_rd; // read view of system control
    logic [SCM_CNT_W-1:0] hold_cyc; // hold for requested frequency
    logic [1:0] new_rc; // rc code from write data

    assign apb_access = psel && penable;
    assign apb_done = apb_access && st.pready;
    assign cpu_tick = st.cpu_src ? main_tick : sub_tick;
    assign new_rc = pwdata[SCM_BIT_RC_HI:SCM_BIT_RC_LO];

    // read view, unused bits forced to zero
    always_comb begin
        sys_ctrl_rd = 8'h00;
        sys_ctrl_rd[SCM_BIT_TIMER_SRC] = st.timer_src;
        sys_ctrl_rd[SCM_BIT_CPU_SRC] = st.cpu_src;
        sys_ctrl_rd[SCM_BIT_IDLE] = st.idle_en;
        sys_ctrl_rd[SCM_BIT_RC_HI:SCM_BIT_RC_LO] = st.rc_sel;
    end

    // settle time of the newly selected frequency
    always_comb begin
        unique case (new_rc)
            SCM_RC_4M: hold_cyc = SCM_CNT_W'(SCM_HOLD_4M_CYC);
            SCM_RC_16M: hold_cyc = SCM_CNT_W'(SCM_HOLD_16M_CYC);
            SCM_RC_8M: hold_cyc = SCM_CNT_W'(SCM_HOLD_8M_CYC);
            SCM_RC_1M: hold_cyc = SCM_CNT_W'(HOLD_1M_CYC);
        endcase
    end

    // ==========================================================
    // next-state logic
    always_comb begin
        next_st = st;
        // apb answer: one wait cycle, then pready
        next_st.pready = apb_access && !st.pready;
        next_st.pslverr = 1'b0;
        if (apb_access && !st.pready) begin
            next_st.prdata = 32'h0000_0000;
            unique case (paddr)
                SCM_ADDR_SYS_CTRL: next_st.prdata[7:0] = sys_ctrl_rd;
                SCM_ADDR_STATUS: begin
                    next_st.prdata[2:0] = st.state;
                    next_st.prdata[3] = st.main_osc_en;
                end
                default: next_st.pslverr = 1'b1; // unmapped
            endcase
        end
        // register write takes effect on the completing edge
        if (apb_done && pwrite && paddr == SCM_ADDR_SYS_CTRL) begin
            next_st.timer_src = pwdata[SCM_BIT_TIMER_SRC];
            next_st.cpu_src = pwdata[SCM_BIT_CPU_SRC];
            next_st.idle_en = pwdata[SCM_BIT_IDLE];
            next_st.rc_sel = new_rc;
            if (new_rc != st.rc_sel) begin
                next_st.state = SCM_FREQ_HOLD;
                next_st.cnt = hold_cyc;
            end
        end
        // timer clock: sub ticks or main divided by two or four
        next_st.timer_clk_en = 1'b0;
        if (main_tick) begin
            next_st.div = st.div + 2'h1;
        end
        if (st.state != SCM_SLEEP) begin
            if (!st.timer_src) begin
                next_st.timer_clk_en = sub_tick;
            end else if (main_tick) begin
                next_st.timer_clk_en = cfg_clk_div4 ? (st.div == 2'h3)
                                                    : st.div[0];
            end
        end
        // operating state machine
        next_st.cpu_clk_en = 1'b0;
        unique case (st.state)
            SCM_RUN: begin
                next_st.cpu_clk_en = cpu_tick;
                if (sleep_instruction) begin
                    next_st.cpu_clk_en = 1'b0;
                    next_st.state = st.idle_en ? SCM_IDLE : SCM_SLEEP;
                end
            end
            SCM_SLEEP, SCM_IDLE: begin
                if (wake_tick) begin
                    next_st.state = SCM_OSC_WAIT;
                end
            end
            SCM_OSC_WAIT: begin
                if (stable_lvl) begin
                    next_st.state = SCM_WAKE_COUNT;
                    if (st.cpu_src && cfg_crystal) begin
                        next_st.cnt = SCM_CNT_W'(SCM_WAKE_XTAL_CNT);
                    end else begin
                        next_st.cnt = SCM_CNT_W'(SCM_WAKE_SHORT_CNT);
                    end
                end
            end
            SCM_WAKE_COUNT: begin
                if (cpu_tick) begin
                    next_st.cnt = st.cnt - SCM_CNT_W'(1);
                    if (st.cnt == SCM_CNT_W'(1)) begin
                        next_st.state = SCM_RUN;
                    end
                end
            end
            SCM_FREQ_HOLD: begin
                // reference clock counts, cpu gated until expiry
                next_st.cnt = st.cnt - SCM_CNT_W'(1);
                if (st.cnt == SCM_CNT_W'(1)) begin
                    next_st.state = SCM_RUN;
                end
            end
        endcase
        // a rewrite with a different code during the hold restarts it for the newest code
        if (apb_done && pwrite && paddr == SCM_ADDR_SYS_CTRL
            && new_rc != st.rc_sel) begin
            next_st.state = SCM_FREQ_HOLD;
            next_st.cnt = hold_cyc;
        end
        // main oscillator off in sleep and while cpu runs on sub
        next_st.main_osc_en = next_st.cpu_src
                              && next_st.state != SCM_SLEEP;
        // mode outputs decoded ahead so they leave a flop directly
        next_st.cpu_hold = (next_st.state == SCM_FREQ_HOLD);
        next_st.sleep_mode = (next_st.state == SCM_SLEEP);
        next_st.idle_mode = (next_st.state == SCM_IDLE);
    end

    // ==========================================================
    // state register, configuration strap caught at reset
    always_ff @(posedge clock) begin
        if (!rstn) begin
            st <= '0;
            st.state <= SCM_RUN;
            st.timer_src <= SCM_RST_TIMER_SRC;
            st.cpu_src <= SCM_RST_CPU_SRC;
            st.idle_en <= SCM_RST_IDLE;
            st.rc_sel <= cfg_rc_freq_sel;
            st.main_osc_en <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs, all straight from state flops
    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign cpu_clk_en = st.cpu_clk_en;
    assign timer_clk_en = st.timer_clk_en;
    assign main_osc_en = st.main_osc_en;
    assign rc_freq_sel = st.rc_sel;
    assign cpu_hold = st.cpu_hold;
    assign sleep_mode = st.sleep_mode;
    assign idle_mode = st.idle_mode;

    // ==========================================================
    // checks
    a_unused_read_zero: assert property (
        @(posedge clock) disable iff (!rstn)
        (pready && psel && !pwrite && paddr == SCM_ADDR_SYS_CTRL)
        |-> (prdata[7] == 1'b0 && prdata[3:2] == 2'h0))
        else $error("unused control bits read nonzero");
    a_timer_sub_src: assert property (
        @(posedge clock) disable iff (!rstn)
        (timer_clk_en && !$past(st.timer_src)) |-> $past(sub_tick))
        else $error("timer enable without sub tick");
    a_cpu_src_tick: assert property (
        @(posedge clock) disable iff (!rstn)
        cpu_clk_en |-> $past(cpu_tick))
        else $error("cpu enable without source tick");
    a_main_osc_off: assert property (
        @(posedge clock) disable iff (!rstn)
        (!st.cpu_src) |-> !main_osc_en)
        else $error("main oscillator runs with sub source");
    a_sleep_mode_pick: assert property (
        @(posedge clock) disable iff (!rstn)
        (st.state == SCM_RUN && sleep_instruction && !apb_done)
        |=> (idle_mode == $past(st.idle_en)) && (sleep_mode != idle_mode))
        else $error("wrong low-power mode entered");
    a_wake_count_load: assert property (
        @(posedge clock) disable iff (!rstn)
        (st.state == SCM_OSC_WAIT && stable_lvl && !apb_done)
        |=> st.cnt == ((st.cpu_src && cfg_crystal) ? SCM_CNT_W'(510)
                                                   : SCM_CNT_W'(8)))
        else $error("wrong wake-up count");
    a_hold_16m: assert property (
        @(posedge clock) disable iff (!rstn)
        (apb_done && pwrite && paddr == SCM_ADDR_SYS_CTRL
         && new_rc == SCM_RC_16M && st.rc_sel != SCM_RC_16M)
        |=> st.cnt == SCM_CNT_W'(375))
        else $error("16 mhz hold is not 375 cycles");
    a_hold_gates_cpu: assert property (
        @(posedge clock) disable iff (!rstn)
        cpu_hold |=> !cpu_clk_en)
        else $error("cpu enabled during hold");
    a_hold_1m: assert property (
        @(posedge clock) disable iff (!rstn)
        (apb_done && pwrite && paddr == SCM_ADDR_SYS_CTRL
         && new_rc == SCM_RC_1M && st.rc_sel != SCM_RC_1M)
        |=> st.cnt == SCM_CNT_W'(HOLD_1M_CYC))
        else $error("1 mhz hold has wrong length");
    c_freq_change: cover property (@(posedge clock) disable iff (!rstn)
        cpu_hold ##1 !cpu_hold);
    c_idle_entry: cover property (@(posedge clock) disable iff (!rstn)
        $rose(idle_mode));
    c_wake_done: cover property (@(posedge clock) disable iff (!rstn)
        st.state == SCM_WAKE_COUNT ##1 st.state == SCM_RUN);
endmodule : scm_top

// File: dv/test_system_clock_mode_control.sv
`timescale 1ns/1ps
// ==========================================================
// register-level bench for the clock and mode controller
module test_system_clock_mode_control;
    import scm_pkg::*;
    localparam int HOLD_1M = 60; // shortened 1 mhz hold
    localparam int LIMIT = 40000; // cycle ceiling for the run
    logic clock = 1'b0; // 250 mhz reference
    logic rstn = 1'b0; // synchronous reset, active low
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] cfg_rc_freq_sel = 2'h3; // configuration straps
    logic cfg_crystal = 1'b1;
    logic cfg_clk_div4 = 1'b0;
    logic main_osc_clock = 1'b0; // bench-made oscillators
    logic sub_osc_clock = 1'b0;
    logic osc_stable = 1'b1;
    logic wake_req = 1'b0;
    logic sleep_instruction = 1'b0;
    logic cpu_clk_en, timer_clk_en, main_osc_en, cpu_hold;
    logic sleep_mode, idle_mode;
    logic [1:0] rc_freq_sel;
    logic sub_run = 1'b0; // sub oscillator running
    logic [1:0] cur_rc = 2'h3; // code software last wrote
    logic [31:0] rd; // last read data
    logic er; // last error response
    int div = 0;
    int cyc = 0;
    int main_ticks = 0; // rising edges of the main oscillator
    int err_count = 0;
    int checks = 0;
    logic [1:0] codes [4] = '{SCM_RC_16M, SCM_RC_1M, SCM_RC_8M, SCM_RC_4M};
    int holds [4] = '{SCM_HOLD_16M_CYC, HOLD_1M, SCM_HOLD_8M_CYC,
        SCM_HOLD_4M_CYC};

    scm_top #(.HOLD_1M_CYC(HOLD_1M)) DUT (.clock(clock), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg_rc_freq_sel(cfg_rc_freq_sel),
        .cfg_crystal(cfg_crystal), .cfg_clk_div4(cfg_clk_div4),
        .main_osc_clock(main_osc_clock), .sub_osc_clock(sub_osc_clock),
        .osc_stable(osc_stable), .wake_req(wake_req),
        .sleep_instruction(sleep_instruction), .cpu_clk_en(cpu_clk_en),
        .timer_clk_en(timer_clk_en), .main_osc_en(main_osc_en),
        .rc_freq_sel(rc_freq_sel), .cpu_hold(cpu_hold),
        .sleep_mode(sleep_mode), .idle_mode(idle_mode));

    // ==========================================================
    // clock, oscillators (period ten cycles) and timeout
    always #2 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (div == 4) begin
            div <= 0;
            // main oscillator stands still while disabled
            if (main_osc_en === 1'b1) main_osc_clock <= ~main_osc_clock;
            if (main_osc_en === 1'b1 && !main_osc_clock) main_ticks++;
            if (sub_run) sub_osc_clock <= ~sub_osc_clock;
        end else begin
            div <= div + 1;
        end
        // ceiling reached: count it and close the run
        if (cyc == LIMIT) begin
            err_count++;
            complete_run();
        end
    end

    // ==========================================================
    // compare, range, report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic rng(input int n, input int lo, input int hi);
        checks++;
        if (n < lo || n > hi) begin
            err_count++;
            $display("[FAIL] %0t count %0d not in %0d..%0d", $time, n, lo, hi);
        end
    endtask : rng

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // ==========================================================
    // apb transfer: hold request until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [7:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h0, wd};
        @(posedge clock);
        penable <= 1'b1;
        // nothing but pready seen high or the bench ceiling ends this wait
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // cycles during which cpu_hold stands high after a write
    task automatic hold_len(output int n);
        n = 0;
        // first look just after the completing edge of the write
        #1;
        while (cpu_hold === 1'b1 && n < 8000) begin
            n++;
            @(posedge clock);
            #1;
        end
    endtask : hold_len

    // count enable pulses over a window
    task automatic count_en(input int w, output int nc, output int nt);
        nc = 0;
        nt = 0;
        repeat (w) begin
            @(posedge clock);
            #1;
            nc += (cpu_clk_en === 1'b1);
            nt += (timer_clk_en === 1'b1);
        end
    endtask : count_en

    // sleep or idle, wake, measure the post-stable count in main ticks
    task automatic wake_run(input logic idle_bit, input int lo, input int hi);
        int n;
        int t0;
        apb(1'b1, SCM_ADDR_SYS_CTRL, {3'h3, idle_bit, 2'h0, cur_rc});
        @(posedge clock);
        sleep_instruction <= 1'b1;
        @(posedge clock);
        sleep_instruction <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        check(sleep_mode, !idle_bit);
        check(idle_mode, idle_bit);
        @(posedge clock);
        osc_stable <= 1'b0;
        wake_req <= 1'b1;
        repeat (8) @(posedge clock);
        osc_stable <= 1'b1;
        wake_req <= 1'b0;
        n = 0;
        do begin
            apb(1'b0, SCM_ADDR_STATUS, 8'h00);
            n++;
        end while (rd[2:0] !== 3'h4 && n < 200);
        t0 = main_ticks;
        n = 0;
        do begin
            apb(1'b0, SCM_ADDR_STATUS, 8'h00);
            n++;
        end while (rd[2:0] === 3'h4 && n < 3000);
        rng(main_ticks - t0, lo, hi);
        check({29'h0, rd[2:0]}, 32'h0);
    endtask : wake_run

    // ==========================================================
    // main sequence
    initial begin
        int n;
        int nc;
        int nt;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        #1;
        check(rc_freq_sel, 2'h3);
        apb(1'b0, SCM_ADDR_SYS_CTRL, 8'h00);
        check(rd, 32'h63);
        apb(1'b1, SCM_ADDR_SYS_CTRL, 8'hFF);
        apb(1'b0, SCM_ADDR_SYS_CTRL, 8'h00);
        check(rd, 32'h73);
        apb(1'b1, SCM_ADDR_SYS_CTRL, 8'h63);
        apb(1'b0, 8'h08, 8'h00);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        // every frequency code, each with its own hold
        for (int i = 0; i < 4; i++) begin
            cur_rc = codes[i];
            apb(1'b1, SCM_ADDR_SYS_CTRL, {6'h18, codes[i]});
            hold_len(n);
            check(32'(n), 32'(holds[i]));
            check(rc_freq_sel, codes[i]);
        end
        // main source: cpu per tick, timer at main over two
        count_en(400, nc, nt);
        rng(nc, 37, 43);
        rng(nt, 17, 23);
        // sub source with sub stopped, then running
        apb(1'b1, SCM_ADDR_SYS_CTRL, {6'h00, cur_rc});
        repeat (10) @(posedge clock);
        check(main_osc_en, 1'b0);
        count_en(400, nc, nt);
        check(32'(nc + nt), 32'h0);
        sub_run <= 1'b1;
        count_en(400, nc, nt);
        rng(nc, 37, 43);
        rng(nt, 37, 43);
        apb(1'b1, SCM_ADDR_SYS_CTRL, {6'h18, cur_rc});
        repeat (20) @(posedge clock);
        check(main_osc_en, 1'b1);
        wake_run(1'b0, 507, 513);
        wake_run(1'b1, 507, 513);
        // second reset: rc straps zero, non-crystal source
        @(posedge clock);
        rstn <= 1'b0;
        cfg_rc_freq_sel <= 2'h0;
        cfg_crystal <= 1'b0;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        cur_rc = 2'h0;
        @(posedge clock);
        #1;
        check(rc_freq_sel, 2'h0);
        apb(1'b0, SCM_ADDR_SYS_CTRL, 8'h00);
        check(rd, 32'h60);
        wake_run(1'b0, 6, 11);
        // timer at main over four
        cfg_clk_div4 <= 1'b1;
        count_en(400, nc, nt);
        rng(nc, 37, 43);
        rng(nt, 8, 12);
        complete_run();
    end
endmodule : test_system_clock_mode_control
